/* File: core/lpd_map.svh */
// offsets, field positions, reset values and timing counts of the led pwm driver
// assumes a 250 MHz mclk and a byte-wide register space shared by both buses
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH

`define LPD_NCH           24
`define LPD_NREG          40
`define LPD_IDX_MODE      6'h00
`define LPD_IDX_GRPPWM    6'h01
`define LPD_IDX_GRPFREQ   6'h02
`define LPD_IDX_CHASE     6'h03
`define LPD_IDX_LEDOUT0   6'h04
`define LPD_IDX_ALLCALL   6'h0A
`define LPD_IDX_SUB1      6'h0B
`define LPD_IDX_STATUS    6'h0E
`define LPD_IDX_PWM0      6'h10

`define LPD_MODE_BLINK    0
`define LPD_MODE_ACKUPD   1
`define LPD_MODE_ALLEN    3
`define LPD_MODE_SUB1EN   4

`define LPD_RST_MODE      8'h08
`define LPD_RST_GRPPWM    8'hFF
`define LPD_RST_ALLCALL   8'h70
`define LPD_RST_SUB1      8'h71
`define LPD_RST_SUB2      8'h72
`define LPD_RST_SUB3      8'h74
`define LPD_SOFT_RESET_CALL_BYTE    8'h06

`define LPD_MCLK_HZ       250000000
`define LPD_MCLK_NS       4
`define LPD_OSC_HZ        25000000
`define LPD_IND_HZ        97000
`define LPD_DIM_HZ        190
`define LPD_BLINK_MAX_US  10730000
`define LPD_GLITCH_NS     50

`define LPD_OSC_DIV       (`LPD_MCLK_HZ / `LPD_OSC_HZ)
`define LPD_IND_STEP      (`LPD_OSC_HZ / (`LPD_IND_HZ * 256))
`define LPD_DIM_STEP      (`LPD_OSC_HZ / (`LPD_DIM_HZ * 256))
`define LPD_BLINK_STEP    ((`LPD_OSC_HZ / 1000000) * `LPD_BLINK_MAX_US / 65536)
`define LPD_GLITCH_CYC    (`LPD_GLITCH_NS / `LPD_MCLK_NS)

`endif

/* File: core/lpd_pkg.sv */
// types of the led pwm driver
// assumes lpd_map.svh for all numeric constants
package lpd_pkg;
  typedef logic [31:0] lpd_word_t;

  typedef enum logic [1:0]
  {
    LPD_OUT_OFF = 2'b00,
    LPD_OUT_ON  = 2'b01,
    LPD_OUT_IND = 2'b10,
    LPD_OUT_GRP = 2'b11
  } lpd_mode_e;

  typedef enum logic [3:0]
  {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_AACK = 4'b0010,
    I_PTR  = 4'b0011,
    I_PACK = 4'b0100,
    I_WDAT = 4'b0101,
    I_WACK = 4'b0110,
    I_RDAT = 4'b0111,
    I_RACK = 4'b1000,
    I_SKIP = 4'b1001
  } lpd_i2c_e;

  typedef struct packed
  {
    logic       en;
    logic [5:0] idx;
    logic [7:0] data;
  } lpd_wr_s;
endpackage

/* File: core/lpd_pin_filter.sv */
// synchroniser and noise filter for asynchronous pins
// assumes pins idle high; output changes only after STABLE equal samples
`timescale 1ns/1ps
module lpd_pin_filter
#(
  parameter int WIDTH  = 1,
  parameter int STABLE = 12
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_clean
);
  generate
    if (WIDTH < 1 || STABLE < 1 || STABLE > 255)
    begin : g_bad
      $error("lpd_pin_filter: unsupported parameters");
    end
  endgenerate

  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= '1;
      sync_b <= '1;
    end
    else
    begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    logic [7:0] cnt;
    logic       q;
    assign pin_clean[g] = q;
    // a change must persist STABLE cycles
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt <= 8'h00;
        q   <= 1'b1;
      end
      else if (sync_b[g] == q)
        cnt <= 8'h00;
      else if (cnt == 8'(STABLE - 1))
      begin
        cnt <= 8'h00;
        q   <= sync_b[g];
      end
      else
        cnt <= cnt + 8'h01;
    end
  end
endmodule

/* File: core/lpd_led_pwm_top.sv */
// 24-channel led dimming and blinking controller with serial bus slave
// assumes Avalon-MM master on mclk; serial bus, address and enable pins are asynchronous
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "lpd_map.svh"
module lpd_led_pwm_top
#(
  parameter int NCH        = `LPD_NCH,
  parameter int OSC_DIV    = `LPD_OSC_DIV,
  parameter int IND_STEP   = `LPD_IND_STEP,
  parameter int DIM_STEP   = `LPD_DIM_STEP,
  parameter int BLINK_STEP = `LPD_BLINK_STEP,
  parameter int GLITCH_CYC = `LPD_GLITCH_CYC
)
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire lpd_pkg::lpd_word_t avs_writedata,
  output lpd_pkg::lpd_word_t     avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [6:0]        hw_addr_pin,
  input  wire logic              oe_pin_n,
  output logic [NCH-1:0]         sink_output_do,
  output logic [NCH-1:0]         sink_output_oe
);
  import lpd_pkg::*;

  localparam int NREG = `LPD_NREG;

  generate
    if (NCH != 24 || OSC_DIV < 1 || IND_STEP < 1 || DIM_STEP < 1 || BLINK_STEP < 1 ||
        OSC_DIV > 65535 || IND_STEP > 65535 || DIM_STEP > 65535 || BLINK_STEP > 65535)
    begin : g_bad
      $error("lpd_led_pwm_top: unsupported parameter set");
    end
  endgenerate

  logic [1:0]   rst_pipe;
  logic         rst_n;
  logic [9:0]   pins_f;
  logic         scl_f;
  logic         sda_f;
  logic [6:0]   hw_addr_f;
  logic         oe_n_f;
  logic         scl_d;
  logic         sda_d;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_seen;
  logic         stop_seen;
  lpd_i2c_e     st;
  logic [3:0]   bit_cnt;
  logic [7:0]   shreg;
  logic [5:0]   ptr;
  logic [5:0]   next_ptr;
  logic         rd_mode;
  logic         soft_reset_call_hit;
  logic         dirty;
  logic         commit;
  logic         soft_rst;
  lpd_wr_s      i2c_wr;
  lpd_wr_s      av_wr;
  logic [7:0]   stage [NREG];
  logic [7:0]   live [NREG];
  logic [5:0]   av_idx;
  lpd_word_t    av_rdata;
  logic [15:0]  div_cnt;
  logic [15:0]  ind_pre;
  logic [15:0]  dim_pre;
  logic [15:0]  blk_pre;
  logic [7:0]   blk_frac;
  logic         osc_tick;
  logic [7:0]   ind_cnt;
  logic [7:0]   grp_cnt;
  logic         grp_act;
  logic [NCH-1:0] ind_act;
  logic [NCH-1:0] ch_on;
  logic [NCH-1:0] chase_en;
  logic [NCH-1:0] next_sink;
  lpd_mode_e    ch_mode [NCH];
  logic [15:0]  tick_gap;

  function automatic logic [7:0] reg_default(input int idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == int'(`LPD_IDX_MODE))
      v = `LPD_RST_MODE;
    else if (idx == int'(`LPD_IDX_GRPPWM))
      v = `LPD_RST_GRPPWM;
    else if (idx == int'(`LPD_IDX_ALLCALL))
      v = `LPD_RST_ALLCALL;
    else if (idx == int'(`LPD_IDX_SUB1))
      v = `LPD_RST_SUB1;
    else if (idx == int'(`LPD_IDX_SUB1) + 1)
      v = `LPD_RST_SUB2;
    else if (idx == int'(`LPD_IDX_SUB1) + 2)
      v = `LPD_RST_SUB3;
    return v;
  endfunction

  function automatic logic reg_writable(input logic [5:0] idx);
    return (idx < 6'(NREG)) && (idx != `LPD_IDX_STATUS);
  endfunction

  function automatic logic addr_hit(input logic [7:0] b);
    logic [6:0] a;
    logic       hit;
    a   = b[7:1];
    hit = (a == hw_addr_f);
    if (live[`LPD_IDX_MODE][`LPD_MODE_ALLEN] && a == live[`LPD_IDX_ALLCALL][6:0])
      hit = 1'b1;
    for (int k = 0; k < 3; k++)
      if (live[`LPD_IDX_MODE][`LPD_MODE_SUB1EN + k] && a == live[`LPD_IDX_SUB1 + k][6:0])
        hit = 1'b1;
    if (b == `LPD_SOFT_RESET_CALL_BYTE)
      hit = 1'b1;
    return hit;
  endfunction

  function automatic logic [NCH-1:0] chase_decode(input logic [7:0] c);
    logic [NCH-1:0] m;
    m = '1;
    if (c != 8'h00)
      for (int k = 0; k < NCH; k++)
        m[k] = c[k / 3];
    return m;
  endfunction

  // reset release
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // pin sync and noise filter
  lpd_pin_filter #(.WIDTH(10), .STABLE(GLITCH_CYC)) u_filt
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_raw   ({oe_pin_n, hw_addr_pin, sda_in, scl_in}),
    .pin_clean (pins_f)
  );
  assign scl_f     = pins_f[0];
  assign sda_f     = pins_f[1];
  assign hw_addr_f = pins_f[8:2];
  assign oe_n_f    = pins_f[9];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end
  assign scl_rise   = scl_f & ~scl_d;
  assign scl_fall   = ~scl_f & scl_d;
  assign start_seen = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_seen  = scl_f & scl_d & ~sda_d & sda_f;
  assign next_ptr   = (ptr == 6'(NREG - 1)) ? 6'h00 : ptr + 6'h01;

  // serial bus slave
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st        <= I_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= 6'h00;
      rd_mode   <= 1'b0;
      soft_reset_call_hit <= 1'b0;
      sda_oe    <= 1'b0;
      dirty     <= 1'b0;
      commit    <= 1'b0;
      soft_rst  <= 1'b0;
      i2c_wr    <= '0;
    end
    else
    begin
      i2c_wr.en <= 1'b0;
      commit    <= 1'b0;
      soft_rst  <= 1'b0;
      if (stop_seen)
      begin
        st     <= I_IDLE;
        sda_oe <= 1'b0;
        commit <= dirty;
        dirty  <= 1'b0;
      end
      else if (start_seen)
      begin
        st      <= I_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end
      else
        case (st)
          I_ADDR, I_PTR, I_WDAT:
            if (scl_rise)
            begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (st == I_ADDR)
              begin
                if (addr_hit(shreg))
                begin
                  sda_oe    <= 1'b1;
                  st        <= I_AACK;
                  rd_mode   <= shreg[0];
                  soft_reset_call_hit <= (shreg == `LPD_SOFT_RESET_CALL_BYTE);
                end
                else
                  st <= I_SKIP;
              end
              else if (st == I_PTR)
              begin
                ptr    <= reg_writable(shreg[5:0]) ? shreg[5:0] : 6'h00;
                sda_oe <= 1'b1;
                st     <= I_PACK;
              end
              else
              begin
                i2c_wr <= '{en: reg_writable(ptr), idx: ptr, data: shreg};
                dirty  <= dirty | ~live[`LPD_IDX_MODE][`LPD_MODE_ACKUPD];
                ptr    <= next_ptr;
                sda_oe <= 1'b1;
                st     <= I_WACK;
              end
            end
          I_AACK:
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              if (soft_reset_call_hit && !rd_mode)
              begin
                soft_rst <= 1'b1;
                st       <= I_SKIP;
              end
              else if (rd_mode)
              begin
                shreg   <= stage[ptr];
                sda_oe  <= ~stage[ptr][7];
                bit_cnt <= 4'h1;
                ptr     <= next_ptr;
                st      <= I_RDAT;
              end
              else
                st <= I_PTR;
            end
          I_PACK, I_WACK:
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              st     <= I_WDAT;
            end
          I_RDAT:
            if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
                st      <= I_RACK;
              end
              else
              begin
                sda_oe  <= ~shreg[6];
                shreg   <= {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          I_RACK:
            if (scl_rise && sda_f)
              st <= I_SKIP;
            else if (scl_fall)
            begin
              shreg   <= stage[ptr];
              sda_oe  <= ~stage[ptr][7];
              bit_cnt <= 4'h1;
              ptr     <= next_ptr;
              st      <= I_RDAT;
            end
          default:
            sda_oe <= 1'b0;
        endcase
    end
  end

  // Avalon-MM slave, one wait state
  assign av_idx = avs_address[7:2];

  always_comb
  begin
    av_rdata = 32'h0000_0000;
    if (avs_address[1:0] != 2'h0)
      av_rdata = 32'h0000_0000;
    else if (av_idx == `LPD_IDX_STATUS)
      av_rdata = {8'h00, sink_output_oe};
    else if (av_idx < 6'(NREG))
      av_rdata = {24'h00_0000, stage[av_idx]};
  end

  always_comb
  begin
    av_wr.en   = avs_write && !avs_waitrequest && avs_address[1:0] == 2'h0 && reg_writable(av_idx);
    av_wr.idx  = av_idx;
    av_wr.data = avs_writedata[7:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= av_rdata;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // staged and live register copies
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        stage[i] <= reg_default(i);
        live[i]  <= reg_default(i);
      end
    end
    else if (soft_rst)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        stage[i] <= reg_default(i);
        live[i]  <= reg_default(i);
      end
    end
    else
    begin
      if (commit)
        for (int i = 0; i < NREG; i++)
          live[i] <= stage[i];
      if (i2c_wr.en)
      begin
        stage[i2c_wr.idx] <= i2c_wr.data;
        if (live[`LPD_IDX_MODE][`LPD_MODE_ACKUPD])
          live[i2c_wr.idx] <= i2c_wr.data;
      end
      if (av_wr.en)
      begin
        stage[av_wr.idx] <= av_wr.data;
        live[av_wr.idx]  <= av_wr.data;
      end
    end
  end

  // timebase and pwm counters
  assign osc_tick = (div_cnt == 16'(OSC_DIV - 1));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt  <= 16'h0000;
      ind_pre  <= 16'h0000;
      dim_pre  <= 16'h0000;
      blk_pre  <= 16'h0000;
      blk_frac <= 8'h00;
      ind_cnt  <= 8'h00;
      grp_cnt  <= 8'h00;
    end
    else if (soft_rst)
    begin
      div_cnt  <= 16'h0000;
      ind_pre  <= 16'h0000;
      dim_pre  <= 16'h0000;
      blk_pre  <= 16'h0000;
      blk_frac <= 8'h00;
      ind_cnt  <= 8'h00;
      grp_cnt  <= 8'h00;
    end
    else
    begin
      div_cnt <= osc_tick ? 16'h0000 : div_cnt + 16'h0001;
      if (osc_tick)
      begin
        if (ind_pre == 16'(IND_STEP - 1))
        begin
          ind_pre <= 16'h0000;
          ind_cnt <= ind_cnt + 8'h01;
        end
        else
          ind_pre <= ind_pre + 16'h0001;
        if (dim_pre == 16'(DIM_STEP - 1))
        begin
          dim_pre <= 16'h0000;
          if (!live[`LPD_IDX_MODE][`LPD_MODE_BLINK])
            grp_cnt <= grp_cnt + 8'h01;
        end
        else
          dim_pre <= dim_pre + 16'h0001;
        if (blk_pre == 16'(BLINK_STEP - 1))
        begin
          blk_pre <= 16'h0000;
          if (blk_frac >= live[`LPD_IDX_GRPFREQ])
          begin
            blk_frac <= 8'h00;
            if (live[`LPD_IDX_MODE][`LPD_MODE_BLINK])
              grp_cnt <= grp_cnt + 8'h01;
          end
          else
            blk_frac <= blk_frac + 8'h01;
        end
        else
          blk_pre <= blk_pre + 16'h0001;
      end
    end
  end

  // output selection
  assign grp_act  = grp_cnt < live[`LPD_IDX_GRPPWM];
  assign chase_en = chase_decode(live[`LPD_IDX_CHASE]);

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    assign ch_mode[i] = lpd_mode_e'(live[`LPD_IDX_LEDOUT0 + i / 4][(i % 4) * 2 +: 2]);
    assign ind_act[i] = ind_cnt < live[`LPD_IDX_PWM0 + i];
    assign ch_on[i]   = (ch_mode[i] == LPD_OUT_ON) ||
                        (ch_mode[i] == LPD_OUT_IND && ind_act[i]) ||
                        (ch_mode[i] == LPD_OUT_GRP && ind_act[i] && grp_act);
  end

  assign next_sink = ch_on & chase_en & {NCH{~oe_n_f}};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sink_output_oe <= '0;
      sink_output_do <= '0;
      sda_out        <= 1'b0;
    end
    else
    begin
      sink_output_oe <= soft_rst ? '0 : next_sink;
      sink_output_do <= '0;
      sda_out        <= 1'b0;
    end
  end

  // cycles since the last timebase tick
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_gap <= 16'h0000;
    else if (osc_tick || soft_rst)
      tick_gap <= 16'h0000;
    else
      tick_gap <= tick_gap + 16'h0001;
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_done;
    st == I_ADDR && scl_fall && bit_cnt == 4'h8;
  endsequence

  sequence s_soft_reset_call_ack;
    st == I_AACK && scl_fall && soft_reset_call_hit && !rd_mode;
  endsequence

  a_oe_gates_all: assert property (oe_n_f |=> sink_output_oe == '0)
    else $error("outputs driven while output enable high");
  a_chase_masks: assert property (##1 (sink_output_oe & ~$past(chase_en)) == '0)
    else $error("chase-disabled output driven");
  a_off_release: assert property (ch_mode[0] == LPD_OUT_OFF |=> !sink_output_oe[0])
    else $error("off output driven");
  a_on_drives: assert property (ch_mode[1] == LPD_OUT_ON && !oe_n_f && chase_en[1] && !soft_rst
                                |=> sink_output_oe[1])
    else $error("on output not driven");
  a_combined_gate: assert property (ch_mode[3] == LPD_OUT_GRP && !grp_act |=> !sink_output_oe[3])
    else $error("combined output driven without group pwm");
  a_osc_period: assert property (osc_tick == (tick_gap == 16'(OSC_DIV - 1)))
    else $error("timebase tick spacing wrong");
  a_addr_nack: assert property (s_addr_done and !addr_hit(shreg) |=> !sda_oe && st == I_SKIP)
    else $error("unmatched address acknowledged");
  a_allcall_ack: assert property (s_addr_done and (shreg[7:1] == 7'(`LPD_RST_ALLCALL)) &&
                                  live[`LPD_IDX_ALLCALL][6:0] == 7'(`LPD_RST_ALLCALL) &&
                                  live[`LPD_IDX_MODE][`LPD_MODE_ALLEN] |=> sda_oe && st == I_AACK)
    else $error("group call address not acknowledged");
  a_soft_reset_call_defaults: assert property (s_soft_reset_call_ack |=> soft_rst ##1
                                     (live[`LPD_IDX_GRPPWM] == `LPD_RST_GRPPWM &&
                                     live[`LPD_IDX_PWM0] == 8'h00 && sink_output_oe == '0))
    else $error("software reset did not restore defaults");
  a_stop_commit: assert property (stop_seen && dirty |=> commit ##1
                                  live[`LPD_IDX_LEDOUT0 + 1] == stage[`LPD_IDX_LEDOUT0 + 1])
    else $error("staged settings not applied at stop");
endmodule

/* File: dv/lpd_i2c_master.sv */
// serial bus master partner, open-drain data, clock idle high
// assumes the bench resolves the data wire from all pull-downs
`timescale 1ns/1ps
module lpd_i2c_master
#(
  parameter int QTR = 5
)
(
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // a quarter of an 80 ns bit, then move both lines
  task automatic step(input logic c, input logic p);
    repeat (QTR) @(posedge mclk);
    scl <= c;
    sda_pull <= p;
  endtask
  task automatic start;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic stop;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // msb first, then release for the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      step(1'b0, !d[i]);
      step(1'b1, !d[i]);
      step(1'b1, !d[i]);
      step(1'b0, !d[i]);
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    repeat (QTR) @(posedge mclk);
    ack = !sda;
    step(1'b0, 1'b0);
  endtask
  // msb first from the slave, then acknowledge or not
  task automatic rbyte(input logic nak, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      repeat (QTR) @(posedge mclk);
      d[i] = sda;
      step(1'b0, 1'b0);
    end
    step(1'b0, !nak);
    step(1'b1, !nak);
    step(1'b1, !nak);
    step(1'b0, !nak);
  endtask
endmodule

/* File: dv/test_led_pwm_driver_24ch.sv */
// self-checking bench of the led pwm driver
// assumes lpd_i2c_master as the serial bus partner
`timescale 1ns/1ps
`include "lpd_map.svh"
module test_led_pwm_driver_24ch;
  import lpd_pkg::*;
  localparam int P = 2;
  logic        mclk;
  logic        arst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  lpd_word_t   avs_writedata;
  lpd_word_t   avs_readdata;
  logic        avs_waitrequest;
  logic        scl;
  logic        pull;
  logic        sda_out;
  logic        sda_oe;
  logic        sda;
  logic [6:0]  hw_addr_pin;
  logic        oe_pin_n;
  logic [23:0] soe;
  int          n_errors;
  int          check_count;
  lpd_word_t   rd;
  logic        ack;
  logic [7:0]  rb;
  int          c;
  assign sda = !(pull | (sda_oe & !sda_out));
  lpd_led_pwm_top #(.OSC_DIV(P), .DIM_STEP(2), .BLINK_STEP(2), .GLITCH_CYC(2)) dut
  (
    .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .hw_addr_pin(hw_addr_pin), .oe_pin_n(oe_pin_n),
    .sink_output_do(), .sink_output_oe(soe)
  );
  lpd_i2c_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input lpd_word_t s, input lpd_word_t e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic av(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input lpd_word_t e);
    av(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), rd, e);
  endtask
  task automatic xa(input logic [7:0] a, input logic e);
    m.start;
    m.wbyte(a, ack);
    check("ack", ack, e);
    m.stop;
  endtask
  task automatic t_reset;
    rchk(8'h00, 32'h08);
    rchk(8'h04, 32'hFF);
    rchk(8'h28, 32'h70);
    rchk(8'h2C, 32'h71);
    rchk(8'h40, 32'h00);
    rchk(8'h38, 32'h00);
    rchk(8'hA0, 32'h00);
    rchk(8'h01, 32'h00);
  endtask
  task automatic t_modes;
    av(1'b1, 8'h10, 8'hE4);
    av(1'b1, 8'h38, 8'h55);
    repeat (2) @(posedge mclk);
    check("oe", soe, 24'h2);
    rchk(8'h38, 32'h02);
    av(1'b1, 8'h04, 8'h00);
    av(1'b1, 8'h4C, 8'h80);
    av(1'b1, 8'h48, 8'h80);
    c = 0;
    repeat (256 * `LPD_IND_STEP * P)
    begin
      @(posedge mclk);
      if (soe[2] === 1'b1)
        c++;
      if (soe[3] === 1'b1)
        c += 1000;
    end
    check("duty", c, 128 * `LPD_IND_STEP * P);
    av(1'b1, 8'h48, 8'h00);
    av(1'b1, 8'h4C, 8'h00);
    av(1'b1, 8'h04, 8'hFF);
  endtask
  task automatic t_oe;
    oe_pin_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check("oe", soe, 24'h0);
    oe_pin_n <= 1'b0;
    repeat (10) @(posedge mclk);
    check("oe", soe, 24'h2);
  endtask
  task automatic t_chase;
    av(1'b1, 8'h14, 8'h55);
    rchk(8'h38, 32'hF2);
    av(1'b1, 8'h0C, 8'h01);
    rchk(8'h38, 32'h02);
    av(1'b1, 8'h0C, 8'h02);
    rchk(8'h38, 32'h30);
    av(1'b1, 8'h0C, 8'h00);
    rchk(8'h38, 32'hF2);
  endtask
  task automatic t_bus;
    m.start;
    m.wbyte(8'hE0, ack);
    check("ack", ack, 1'b1);
    m.wbyte(8'h05, ack);
    m.wbyte(8'h00, ack);
    check("ack", ack, 1'b1);
    rchk(8'h38, 32'hF2);
    m.stop;
    repeat (10) @(posedge mclk);
    rchk(8'h38, 32'h02);
    m.start;
    m.wbyte(8'h54, ack);
    m.wbyte(8'h00, ack);
    m.stop;
    m.start;
    m.wbyte(8'h55, ack);
    check("ack", ack, 1'b1);
    m.rbyte(1'b1, rb);
    m.stop;
    check("read", rb, 32'h08);
    xa(8'h54, 1'b1);
    xa(8'hE2, 1'b0);
    xa(8'h07, 1'b0);
    av(1'b1, 8'h00, 8'h18);
    xa(8'hE2, 1'b1);
  endtask
  task automatic t_soft_reset_call;
    av(1'b1, 8'h04, 8'h10);
    xa(8'h06, 1'b1);
    repeat (10) @(posedge mclk);
    rchk(8'h04, 32'hFF);
    rchk(8'h00, 32'h08);
    rchk(8'h10, 32'h00);
    check("oe", soe, 24'h0);
  endtask
  initial
  begin
    n_errors = 0;
    check_count = 0;
    arst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    hw_addr_pin = 7'h2A;
    oe_pin_n = 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset;
    t_modes;
    t_oe;
    t_chase;
    t_bus;
    t_soft_reset_call;
    conclude;
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    conclude;
  end
endmodule
